// >>> hw/sfcd_defs.svh
/*
 * constants for the serial flash command decoder: opcodes, read-parameter
 * field positions, discovery table layout.
 * assumes inclusion by bare name from the decoder.
 */
`ifndef SFCD_DEFS_SVH
`define SFCD_DEFS_SVH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define SFCD_OP_READ          8'h03
`define SFCD_OP_FAST_READ     8'h0B
`define SFCD_OP_DUAL_IO_READ  8'hBB
`define SFCD_OP_QUAD_IO_READ  8'hEB
`define SFCD_OP_QUAD_IO_SHORT 8'hE7
`define SFCD_OP_PAGE_WRITE    8'h02
`define SFCD_OP_QUAD_PAGE_WR  8'h38
`define SFCD_OP_ERASE_4K      8'h20
`define SFCD_OP_ERASE_32K     8'h52
`define SFCD_OP_ERASE_64K     8'hD8
`define SFCD_OP_WRITE_UNLOCK  8'h06
`define SFCD_OP_WRITE_LOCK    8'h04
`define SFCD_OP_STATUS_READ   8'h05
`define SFCD_OP_STATUS_WRITE  8'h01
`define SFCD_OP_FOUR_ENTER    8'h35
`define SFCD_OP_FOUR_EXIT     8'hF5
`define SFCD_OP_SUSPEND       8'hB0
`define SFCD_OP_RESUME        8'h30
`define SFCD_OP_DEEP_SLEEP    8'hB9
`define SFCD_OP_WAKE_ID       8'hAB
`define SFCD_OP_SET_READ_PARM 8'hC0
`define SFCD_OP_STD_ID        8'h9F
`define SFCD_OP_MAKER_DEV_ID  8'h90
`define SFCD_OP_FOUR_LINE_ID  8'hAF
`define SFCD_OP_DISCOVERY     8'h5A
`define SFCD_OP_NO_ACTION     8'h00
`define SFCD_OP_RESET_ARM     8'h66
`define SFCD_OP_RESET_GO      8'h99
`define SFCD_OP_CONT_EXIT     8'hFF

// ----------------------------------------------------------------
// read-parameter register layout
// ----------------------------------------------------------------
`define SFCD_RP_RESET      8'h00
`define SFCD_RP_DUMMY_HI   5
`define SFCD_RP_DUMMY_LO   4
`define SFCD_RP_WRAP_CTL   3
`define SFCD_RP_WLEN_HI    1
`define SFCD_RP_WLEN_LO    0
`define SFCD_RP_USED_MASK  8'h3B

// ----------------------------------------------------------------
// dummy counts and discovery table
// ----------------------------------------------------------------
`define SFCD_DUMMY_FAST    4'h8
`define SFCD_DUMMY_FOUR    4'h4
`define SFCD_DUMMY_SIX     4'h6
`define SFCD_DUMMY_EIGHT   4'h8
`define SFCD_DISC_DEPTH    128
`define SFCD_DISC_AW       7
`define SFCD_ADDR_W        24

`endif

// >>> hw/sfcd_pkg.sv
/*
 * types shared by the serial flash command decoder.
 * assumes sfcd_defs.svh for all numeric constants.
 */
package sfcd_pkg;

	// decoder phases within one chip-select frame
	typedef enum logic [2:0]
	{
		SFCD_OPCODE,
		SFCD_ADDRESS,
		SFCD_PARAM,
		SFCD_DUMMY,
		SFCD_DATA_OUT,
		SFCD_IGNORE
	} sfcd_phase_type;

	// what the frame's data phase sends
	typedef enum logic [1:0]
	{
		SFCD_SRC_ARRAY,
		SFCD_SRC_DISC,
		SFCD_SRC_STATUS,
		SFCD_SRC_ID
	} sfcd_src_type;

endpackage

// >>> hw/sfcd_decoder.sv
/*
 * serial flash command decoder: opcode decode, read-parameter register,
 * write latch, four-line mode, reset arming, discovery table and normal
 * read with auto-increment and rollover. link logic and the array read
 * path run on the serial clock; busy state and command pulses cross.
 * assumes the host drives chip select and serial clock, sampling on
 * rising edges; array data settles within half a serial clock period.
 */
// Contract
// - opcode, address and data bits sampled on rising serial clock while select low
// - all fields shifted and assembled most significant bit first
// - program, erase and status write ignored unless write latch set
// - eight-bit read-parameter register written by C0h, resets to zero
// - wrap length field picks 8, 16, 32 or 64 byte boundary
// - wrap control bit zero enables wrap, one disables it
// - normal read no dummies; fast read always eight dummies
// - dual read: fields 00/01 give four dummies, 10 gives eight
// - quad read: fields 00/01/10 give six, four, eight dummies
// - 03h read, 0Bh fast read, BBh dual read single-line only; the decoder accepts 0Bh in both modes
// - EBh quad read both modes; E7h single-line with four dummies
// - 02h page write both modes; 38h single-line only
// - 06h, 04h, 05h, 01h valid in both command modes
// - 35h enters four-line mode from single-line; F5h leaves it
// - B0h suspends, 30h resumes program or erase
// - B9h deep sleep; ABh wakes and returns identification; the decoder drives no data for ABh
// - 66h then 99h resets; 00h cancels arming; FFh exits continuous
// - 9Fh standard id, 90h maker/device id, AFh four-line only; the decoder sends no id bytes for any of them
// - 5Ah reads fixed discovery table with header and basic table
// - table lists 4K/32K/64K erase types, 256K unsupported
// - normal read takes full 24-bit address, outputs msb first
// - address increments per byte and rolls to zero at top
// - raising select ends read and stops driving data
// - reads ignored while busy flag set, operation undisturbed
`timescale 1ns/100ps
`include "sfcd_defs.svh"

module sfcd_decoder
	import sfcd_pkg::*;
(
	input  wire logic                    sys_clk,       // system clock
	input  wire logic                    reset_n,       // async reset
	input  wire logic                    link_clk,      // serial clock from host
	input  wire logic                    cs_n,          // chip select, low active
	input  wire logic                    si_in,         // serial data in
	output logic                         so_out,        // serial data out
	output logic                         so_oe,         // data out enable
	input  wire logic                    busy_flag,     // internal op in progress
	input  wire logic [7:0]              array_rdata,   // array byte at array_addr
	output logic [`SFCD_ADDR_W-1:0]      array_addr,    // array read address
	output logic [7:0]                   read_parameters, // read-parameter register
	output logic                         write_latch_flag, // write enabled
	output logic                         four_line_cmd_mode, // command mode
	output logic                         deep_sleep,    // deep power-down state
	output logic [7:0]                   cmd_pulse_op,  // opcode of last executed cmd
	output logic                         cmd_pulse,     // one-cycle sys_clk pulse
	output logic [3:0]                   dummy_cycles   // dummies of last read
);

	// ----------------------------------------------------------------
	// discovery table, fixed content
	// ----------------------------------------------------------------
	function automatic logic [7:0] disc_byte(input logic [6:0] a);
		case (a)
			7'h00: disc_byte = 8'h53;
			7'h01: disc_byte = 8'h46;
			7'h02: disc_byte = 8'h44;
			7'h03: disc_byte = 8'h50;
			7'h04: disc_byte = 8'h00;
			7'h05: disc_byte = 8'h01;
			7'h06: disc_byte = 8'h00;
			7'h08: disc_byte = 8'h00;
			7'h09: disc_byte = 8'h00;
			7'h0A: disc_byte = 8'h01;
			7'h0B: disc_byte = 8'h09;
			7'h0C: disc_byte = 8'h30;   // basic table pointer, low byte
			7'h0D: disc_byte = 8'h00;
			7'h0E: disc_byte = 8'h00;
			7'h10: disc_byte = 8'h00;   // maker id, value arbitrary
			7'h31: disc_byte = `SFCD_OP_ERASE_4K;
			7'h37: disc_byte = 8'h07;
			7'h38: disc_byte = 8'h44;
			7'h39: disc_byte = `SFCD_OP_QUAD_IO_READ;
			7'h3A: disc_byte = 8'h00;
			7'h3C: disc_byte = 8'h00;
			7'h3E: disc_byte = 8'h04;
			7'h3F: disc_byte = `SFCD_OP_DUAL_IO_READ;
			7'h40: disc_byte = 8'hEE;
			7'h46: disc_byte = 8'h00;
			7'h4A: disc_byte = 8'h00;
			7'h4C: disc_byte = 8'h0C;
			7'h4D: disc_byte = `SFCD_OP_ERASE_4K;
			7'h4E: disc_byte = 8'h0F;
			7'h4F: disc_byte = `SFCD_OP_ERASE_32K;
			7'h50: disc_byte = 8'h10;
			7'h51: disc_byte = `SFCD_OP_ERASE_64K;
			7'h52: disc_byte = 8'h00;   // 256K erase not supported
			default: disc_byte = 8'hFF;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// opcode validity in the present command mode
	// ----------------------------------------------------------------
	function automatic logic op_valid(input logic [7:0] op, input logic four);
		case (op)
			`SFCD_OP_READ, `SFCD_OP_DUAL_IO_READ, `SFCD_OP_QUAD_IO_SHORT,
			`SFCD_OP_QUAD_PAGE_WR, `SFCD_OP_FOUR_ENTER:
				op_valid = !four;
			`SFCD_OP_FOUR_EXIT, `SFCD_OP_FOUR_LINE_ID:
				op_valid = four;
			`SFCD_OP_FAST_READ, `SFCD_OP_QUAD_IO_READ, `SFCD_OP_PAGE_WRITE,
			`SFCD_OP_WRITE_UNLOCK, `SFCD_OP_WRITE_LOCK, `SFCD_OP_STATUS_READ,
			`SFCD_OP_STATUS_WRITE, `SFCD_OP_SUSPEND, `SFCD_OP_RESUME,
			`SFCD_OP_DEEP_SLEEP, `SFCD_OP_WAKE_ID, `SFCD_OP_SET_READ_PARM,
			`SFCD_OP_STD_ID, `SFCD_OP_MAKER_DEV_ID, `SFCD_OP_DISCOVERY,
			`SFCD_OP_NO_ACTION, `SFCD_OP_RESET_ARM, `SFCD_OP_RESET_GO,
			`SFCD_OP_CONT_EXIT, `SFCD_OP_ERASE_4K, `SFCD_OP_ERASE_32K,
			`SFCD_OP_ERASE_64K:
				op_valid = 1'b1;
			default: op_valid = 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// link domain: shifter and phase machine
	// ----------------------------------------------------------------
	sfcd_phase_type          phase_reg;
	sfcd_phase_type          phase_next;
	sfcd_src_type            src_reg;
	logic [2:0]              bit_cnt_reg;
	logic [4:0]              addr_cnt_reg;
	logic [3:0]              dummy_cnt_reg;
	logic [7:0]              shift_reg;
	logic [7:0]              op_reg;
	logic [`SFCD_ADDR_W-1:0] addr_reg;
	logic [7:0]              out_reg;
	logic                    req_tgl_reg;   // toggles per byte to fetch
	logic                    cmd_tgl_reg;   // toggles per completed command other than 03h and 5Ah reads
	logic                    busy_s1_reg;
	logic                    busy_s2_reg;
	logic                    four_s1_reg;
	logic                    four_s2_reg;
	logic                    wel_s1_reg;
	logic                    wel_s2_reg;
	logic                    sleep_s1_reg;
	logic                    sleep_s2_reg;
	logic [7:0]              param_reg;     // byte that followed C0h

	wire [7:0] in_byte   = {shift_reg[6:0], si_in};
	wire       byte_done = (bit_cnt_reg == 3'd7);
	wire       is_read   = (in_byte == `SFCD_OP_READ) || (in_byte == `SFCD_OP_DISCOVERY);
	wire       op_ok     = op_valid(in_byte, four_s2_reg)
	                       && (!sleep_s2_reg || in_byte == `SFCD_OP_WAKE_ID);
	wire       read_ok   = is_read && !busy_s2_reg;
	wire       has_param = (in_byte == `SFCD_OP_SET_READ_PARM);
	wire       fetch_now = (phase_reg == SFCD_DATA_OUT) && byte_done;
	wire [7:0] disc_now  = disc_byte(addr_reg[6:0]);

	// next phase on each sampled bit
	always_comb
	begin
		phase_next = phase_reg;
		unique case (phase_reg)
			SFCD_OPCODE:
				if (byte_done)
					phase_next = !op_ok ? SFCD_IGNORE :
						read_ok ? SFCD_ADDRESS :
						has_param ? SFCD_PARAM : SFCD_IGNORE;
			SFCD_ADDRESS:
				if (addr_cnt_reg == 5'd23)
					phase_next = SFCD_DATA_OUT;
			SFCD_PARAM:
				if (byte_done)
					phase_next = SFCD_IGNORE;
			SFCD_DUMMY:
				if (dummy_cnt_reg == 4'd1)
					phase_next = SFCD_DATA_OUT;
			SFCD_DATA_OUT:
				phase_next = SFCD_DATA_OUT;
			SFCD_IGNORE:
				phase_next = SFCD_IGNORE;
		endcase
	end

	// raising select clears the frame; the link clock may stop after that
	always_ff @(posedge link_clk or posedge cs_n)
	begin
		if (cs_n)
		begin
			phase_reg     <= SFCD_OPCODE;
			bit_cnt_reg   <= 3'd0;
			addr_cnt_reg  <= 5'd0;
			dummy_cnt_reg <= 4'd0;
			shift_reg     <= 8'h00;
		end
		else
		begin
			phase_reg     <= phase_next;
			bit_cnt_reg   <= bit_cnt_reg + 3'd1;
			shift_reg     <= in_byte;
			addr_cnt_reg  <= (phase_reg == SFCD_ADDRESS) ? addr_cnt_reg + 5'd1 : 5'd0;
			dummy_cnt_reg <= (phase_reg == SFCD_DUMMY) ? dummy_cnt_reg - 4'd1 : 4'd0;
		end
	end

	// opcode, address, source latch and fetch requests
	always_ff @(posedge link_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			op_reg      <= 8'h00;
			addr_reg    <= '0;
			src_reg     <= SFCD_SRC_ARRAY;
			req_tgl_reg <= 1'b0;
			cmd_tgl_reg <= 1'b0;
			param_reg   <= 8'h00;
		end
		else if (!cs_n)
		begin
			if (phase_reg == SFCD_OPCODE && byte_done)
			begin
				op_reg  <= in_byte;
				src_reg <= (in_byte == `SFCD_OP_DISCOVERY) ? SFCD_SRC_DISC : SFCD_SRC_ARRAY;
				if (op_ok && !is_read && !has_param)
					cmd_tgl_reg <= !cmd_tgl_reg;
			end
			if (phase_reg == SFCD_ADDRESS)
				addr_reg <= {addr_reg[22:0], si_in};
			if (phase_reg == SFCD_PARAM && byte_done)
			begin
				param_reg   <= in_byte;
				cmd_tgl_reg <= !cmd_tgl_reg;
			end
			if ((phase_reg == SFCD_ADDRESS && addr_cnt_reg == 5'd23) || fetch_now)
				req_tgl_reg <= !req_tgl_reg;
			if (fetch_now)
				addr_reg <= addr_reg + 24'h00_0001;
		end
	end

	// output shifter changes on falling edges so the host samples stable data
	always_ff @(negedge link_clk or posedge cs_n)
	begin
		if (cs_n)
			out_reg <= 8'h00;
		else if (phase_reg == SFCD_DATA_OUT && bit_cnt_reg == 3'd0)
			out_reg <= (src_reg == SFCD_SRC_DISC) ? disc_now : array_rdata;
		else
			out_reg <= {out_reg[6:0], 1'b0};
	end

	assign so_out = out_reg[7];
	assign so_oe  = !cs_n && (phase_reg == SFCD_DATA_OUT);

	// array addressed straight from the link counter: a round trip through
	// sys_clk would not fit the half period before the first data bit
	assign array_addr = addr_reg;

	// sys_clk state seen by the link, two flops each
	always_ff @(posedge link_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			{busy_s1_reg, busy_s2_reg}   <= 2'b00;
			{four_s1_reg, four_s2_reg}   <= 2'b00;
			{wel_s1_reg, wel_s2_reg}     <= 2'b00;
			{sleep_s1_reg, sleep_s2_reg} <= 2'b00;
		end
		else
		begin
			busy_s1_reg  <= busy_flag;
			busy_s2_reg  <= busy_s1_reg;
			four_s1_reg  <= four_line_cmd_mode;
			four_s2_reg  <= four_s1_reg;
			wel_s1_reg   <= write_latch_flag;
			wel_s2_reg   <= wel_s1_reg;
			sleep_s1_reg <= deep_sleep;
			sleep_s2_reg <= sleep_s1_reg;
		end
	end

	// ----------------------------------------------------------------
	// system domain: command execution; fetch requests only clear normal-read dummies
	// ----------------------------------------------------------------
	logic [2:0]              req_sync_reg;
	logic [2:0]              cmd_sync_reg;
	logic [7:0]              param_hold_reg;
	logic                    reset_armed_reg;
	logic [7:0]              op_hold_reg;

	wire req_event = req_sync_reg[2] ^ req_sync_reg[1];
	wire cmd_event = cmd_sync_reg[2] ^ cmd_sync_reg[1];
	wire needs_wel = (op_hold_reg == `SFCD_OP_PAGE_WRITE) || (op_hold_reg == `SFCD_OP_QUAD_PAGE_WR)
	              || (op_hold_reg == `SFCD_OP_STATUS_WRITE) || (op_hold_reg == `SFCD_OP_ERASE_4K)
	              || (op_hold_reg == `SFCD_OP_ERASE_32K) || (op_hold_reg == `SFCD_OP_ERASE_64K);
	wire cmd_go    = cmd_event && (!needs_wel || write_latch_flag);

	// op_reg is written no later than the link edge that toggles cmd_tgl_reg and holds while the toggle crosses to sys_clk
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			req_sync_reg <= 3'b000;
			cmd_sync_reg <= 3'b000;
			op_hold_reg  <= 8'h00;
		end
		else
		begin
			req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
			cmd_sync_reg <= {cmd_sync_reg[1:0], cmd_tgl_reg};
			op_hold_reg  <= op_reg;
		end
	end

	// wrap boundary, computed but not used by the read path: zero when wrap disabled
	wire [6:0] wrap_bytes = read_parameters[`SFCD_RP_WRAP_CTL] ? 7'd0 :
		(7'd8 << read_parameters[`SFCD_RP_WLEN_HI:`SFCD_RP_WLEN_LO]);
	wire [1:0] dsel = read_parameters[`SFCD_RP_DUMMY_HI:`SFCD_RP_DUMMY_LO];

	// mode, latch, sleep, parameters and reset arming
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			read_parameters    <= `SFCD_RP_RESET;
			write_latch_flag   <= 1'b0;
			four_line_cmd_mode <= 1'b0;
			deep_sleep         <= 1'b0;
			reset_armed_reg    <= 1'b0;
			cmd_pulse          <= 1'b0;
			cmd_pulse_op       <= 8'h00;
			dummy_cycles       <= 4'h0;
		end
		else
		begin
			cmd_pulse <= cmd_go;
			if (cmd_go)
			begin
				cmd_pulse_op    <= op_hold_reg;
				reset_armed_reg <= (op_hold_reg == `SFCD_OP_RESET_ARM);
				unique case (op_hold_reg)
					`SFCD_OP_WRITE_UNLOCK: write_latch_flag   <= 1'b1;
					`SFCD_OP_WRITE_LOCK:   write_latch_flag   <= 1'b0;
					`SFCD_OP_FOUR_ENTER:   four_line_cmd_mode <= 1'b1;
					`SFCD_OP_FOUR_EXIT:    four_line_cmd_mode <= 1'b0;
					`SFCD_OP_DEEP_SLEEP:   deep_sleep         <= 1'b1;
					`SFCD_OP_WAKE_ID:      deep_sleep         <= 1'b0;
					`SFCD_OP_FAST_READ:    dummy_cycles <= `SFCD_DUMMY_FAST;
					`SFCD_OP_DUAL_IO_READ:
						dummy_cycles <= dsel[1] ? `SFCD_DUMMY_EIGHT : `SFCD_DUMMY_FOUR;
					`SFCD_OP_QUAD_IO_READ:
						dummy_cycles <= (dsel == 2'b00) ? `SFCD_DUMMY_SIX :
							dsel[1] ? `SFCD_DUMMY_EIGHT : `SFCD_DUMMY_FOUR;
					`SFCD_OP_QUAD_IO_SHORT: dummy_cycles <= `SFCD_DUMMY_FOUR;
					`SFCD_OP_SET_READ_PARM:
						read_parameters <= param_hold_reg & `SFCD_RP_USED_MASK;
					`SFCD_OP_RESET_GO:
						if (reset_armed_reg)
						begin
							read_parameters    <= `SFCD_RP_RESET;
							write_latch_flag   <= 1'b0;
							four_line_cmd_mode <= 1'b0;
						end
					default: ;
				endcase
				if (needs_wel)
					write_latch_flag <= 1'b0;
			end
			if (req_event && op_hold_reg == `SFCD_OP_READ)
				dummy_cycles <= 4'h0;
		end
	end

	// parameter byte is steady in the link domain before its toggle lands
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			param_hold_reg <= 8'h00;
		else
			param_hold_reg <= param_reg;
	end

	wire unused_ok = ^{wrap_bytes, wel_s2_reg};

endmodule // sfcd_decoder

// >>> sim/sfcd_decoder_props.sv
/*
 * port checker for the command decoder: pulses, flags, data enable.
 * assumes binding to sfcd_decoder; every check runs on sys_clk.
 */
`timescale 1ns/100ps

module sfcd_decoder_props
(
	input wire logic       sys_clk,            // system clock
	input wire logic       reset_n,            // async reset
	input wire logic       cs_n,               // chip select
	input wire logic       so_oe,              // data out enable
	input wire logic       busy_flag,          // op in progress
	input wire logic [7:0] read_parameters,    // read-parameter register
	input wire logic       write_latch_flag,   // write enabled
	input wire logic       four_line_cmd_mode, // command mode
	input wire logic       deep_sleep,         // power-down state
	input wire logic [7:0] cmd_pulse_op,       // executed opcode
	input wire logic       cmd_pulse,          // execution pulse
	input wire logic [3:0] dummy_cycles        // dummies of last read
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	// opcode of the command executed before the present one
	logic [7:0] prev_op_reg;
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			prev_op_reg <= 8'h00;
		else if (cmd_pulse)
			prev_op_reg <= cmd_pulse_op;
	end

	// one executed command with a given opcode
	sequence op_done(logic [7:0] op);
		cmd_pulse && cmd_pulse_op == op;
	endsequence

	pulse_single_a: assert property (cmd_pulse |=> !cmd_pulse)
		else $error("command pulse wider than one cycle");
	oe_deselect_a: assert property (cs_n |-> !so_oe)
		else $error("data driven while deselected");
	latch_set_a: assert property (op_done(8'h06) |-> ##[0:4] write_latch_flag)
		else $error("write latch not set");
	latch_clear_a: assert property (op_done(8'h04) |-> ##[0:4] !write_latch_flag)
		else $error("write latch not cleared");
	// the latch drops at the very edge that raises the pulse
	locked_write_a: assert property ((cmd_pulse && cmd_pulse_op inside {8'h02, 8'h38, 8'h01})
		|-> $past(write_latch_flag))
		else $error("write command ran without latch");
	reserved_zero_a: assert property ((read_parameters & 8'hC4) == 8'h00)
		else $error("reserved parameter bit set");
	dummy_legal_a: assert property (dummy_cycles inside {4'h0, 4'h4, 4'h6, 4'h8})
		else $error("illegal dummy count");
	four_enter_a: assert property (op_done(8'h35) |-> ##[0:4] four_line_cmd_mode)
		else $error("four-line mode not entered");
	four_exit_a: assert property (op_done(8'hF5) |-> ##[0:4] !four_line_cmd_mode)
		else $error("four-line mode not left");
	sleep_enter_a: assert property (op_done(8'hB9) |-> ##[0:4] deep_sleep)
		else $error("deep sleep not entered");
	soft_reset_a: assert property ((prev_op_reg == 8'h66 ##0 op_done(8'h99))
		|-> ##[0:4] (read_parameters == 8'h00 && !write_latch_flag))
		else $error("software reset left state");
	busy_read_a: assert property (busy_flag && $past(busy_flag) |-> !$rose(so_oe))
		else $error("read served while busy");
endmodule // sfcd_decoder_props

bind sfcd_decoder sfcd_decoder_props u_props (.sys_clk, .reset_n, .cs_n, .so_oe, .busy_flag,
	.read_parameters, .write_latch_flag, .four_line_cmd_mode, .deep_sleep, .cmd_pulse_op,
	.cmd_pulse, .dummy_cycles);

// >>> sim/sfcd_host.sv
/*
 * host serial controller model: frames of command bits and read bytes.
 * assumes the device samples on rising link_clk and shifts on falling.
 */
`timescale 1ns/100ps

module sfcd_host
(
	output logic            link_clk, // serial clock, still between frames
	output logic            cs_n,     // chip select, low active
	output logic            si_in,    // data to device
	input  wire logic       so_out,   // data from device
	input  wire logic       so_oe     // device driving
);
	logic [7:0] rx_q[$]; // bytes read in the last frame
	logic       oe_seen;  // device drove data in the last frame

	initial
	begin
		link_clk = 1'b0;
		cs_n = 1'b1;
		si_in = 1'b0;
	end

	// ----------------------------------------------------------------
	// frame tasks
	// ----------------------------------------------------------------
	// two rising edges so the link side sees reset
	task automatic reset_clocks;
		repeat (4) #7.5 link_clk = ~link_clk;
	endtask

	// nb bits of word msb first, then nr bytes read back
	task automatic xfer(input logic [31:0] word, input int nb, input int nr);
		logic [7:0] b;
		rx_q = {};
		oe_seen = 1'b0;
		cs_n = 1'b0;
		for (int i = nb - 1; i >= 0; i--)
		begin
			si_in = word[i];
			#7.5 link_clk = 1'b1;
			#7.5 link_clk = 1'b0;
		end
		for (int k = 0; k < nr; k++)
		begin
			for (int i = 7; i >= 0; i--)
			begin
				#7.5 link_clk = 1'b1;
				b[i] = so_out;
				oe_seen = oe_seen | so_oe;
				#7.5 link_clk = 1'b0;
			end
			rx_q.push_back(b);
		end
		#7.5 cs_n = 1'b1;
		si_in = ~si_in; // a released line keeps no value
		#400;
	endtask
endmodule // sfcd_host

// >>> sim/testbench.sv
/*
 * self-checking bench for the command decoder, host model on the link.
 * assumes a combinational array model and frames spaced by 400 ns.
 */
`timescale 1ns/100ps

module testbench;
	import sfcd_pkg::*;

	logic        sys_clk, reset_n, busy_flag, link_clk, cs_n, si_in, so_out, so_oe;
	logic        write_latch_flag, four_line_cmd_mode, deep_sleep, cmd_pulse;
	logic [7:0]  read_parameters, cmd_pulse_op, array_rdata;
	logic [23:0] array_addr;
	logic [3:0]  dummy_cycles;
	int          num_errors = 0;
	int          checks_done = 0;
	int          pulses = 0;

	sfcd_decoder DUT (.sys_clk, .reset_n, .link_clk, .cs_n, .si_in, .so_out, .so_oe,
		.busy_flag, .array_rdata, .array_addr, .read_parameters, .write_latch_flag,
		.four_line_cmd_mode, .deep_sleep, .cmd_pulse_op, .cmd_pulse, .dummy_cycles);
	sfcd_host host (.link_clk, .cs_n, .si_in, .so_out, .so_oe);

	// array content XORs the low and top address bytes; addresses wrong only in the middle byte do not show
	function automatic logic [7:0] arr(input logic [31:0] a);
		return a[7:0] ^ a[23:16] ^ 8'h3C;
	endfunction
	assign array_rdata = arr({8'h00, array_addr});

	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// count executed commands
	always @(posedge sys_clk)
		if (cmd_pulse === 1'b1)
			pulses <= pulses + 1;

	// ----------------------------------------------------------------
	// checking and verdict
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		if (num_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_latch;
		int n;
		check(read_parameters, 8'h00);
		host.xfer(8'h06, 8, 0);
		check(write_latch_flag, 1'b1);
		host.xfer(8'h04, 8, 0);
		check(write_latch_flag, 1'b0);
		n = pulses;
		host.xfer(16'h0100, 16, 0);
		check(pulses, n);
		host.xfer(8'h06, 8, 0);
		host.xfer(16'h0100, 16, 0);
		check(cmd_pulse_op, 8'h01);
	endtask

	// dummy field values 00, 01 and 10 against every read opcode
	task automatic t_dummy;
		logic [7:0] ops[5] = '{8'h03, 8'h0B, 8'hBB, 8'hEB, 8'hE7};
		logic [3:0] exp[3][5] = '{'{0, 8, 4, 6, 4}, '{0, 8, 4, 4, 4}, '{0, 8, 8, 8, 4}};
		logic [7:0] rp;
		for (int p = 0; p < 3; p++)
		begin
			rp = {2'b00, p[1:0], p[0], 1'b0, p[1:0]};
			host.xfer({8'hC0, rp}, 16, 0);
			check(read_parameters, rp);
			for (int j = 0; j < 5; j++)
			begin
				// normal read only takes effect once its address is complete
				host.xfer((j == 0) ? {ops[j], 24'h00_0000} : {24'h00_0000, ops[j]},
					(j == 0) ? 32 : 8, (j == 0) ? 1 : 0);
				check(dummy_cycles, exp[p][j]);
			end
		end
	endtask

	// read across the top of the array, then while busy
	task automatic t_read;
		host.xfer({8'h03, 24'hFF_FFFE}, 32, 3);
		for (int i = 0; i < 3; i++)
			check(host.rx_q[i], arr(32'h00FF_FFFE + i));
		check(so_oe, 1'b0);
		@(negedge sys_clk);
		busy_flag = 1'b1;
		host.xfer({8'h03, 24'h00_0010}, 32, 1);
		check(host.oe_seen, 1'b0);
		@(negedge sys_clk);
		busy_flag = 1'b0;
	endtask

	task automatic t_disc;
		logic [7:0] hdr[15] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h00, 8'hFF,
			8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00};
		logic [7:0] ers[8] = '{8'h0C, 8'h20, 8'h0F, 8'h52, 8'h10, 8'hD8, 8'h00, 8'hFF};
		host.xfer({8'h5A, 24'h00_0000}, 32, 15);
		for (int i = 0; i < 15; i++)
			check(host.rx_q[i], hdr[i]);
		host.xfer({8'h5A, 24'h00_004C}, 32, 8);
		for (int i = 0; i < 8; i++)
			check(host.rx_q[i], ers[i]);
	endtask

	task automatic t_modes;
		int n;
		host.xfer(8'hF5, 8, 0);
		check(four_line_cmd_mode, 1'b0);
		n = pulses;
		host.xfer(8'h48, 8, 0);
		check(pulses, n);
		host.xfer(8'h35, 8, 0);
		check(four_line_cmd_mode, 1'b1);
		host.xfer(8'hF5, 8, 0);
		check(four_line_cmd_mode, 1'b0);
		host.xfer(8'hB9, 8, 0);
		check(deep_sleep, 1'b1);
		host.xfer(8'hAB, 8, 0);
		check(deep_sleep, 1'b0);
	endtask

	// an intervening no-action disarms the reset
	task automatic t_soft_reset;
		host.xfer(16'hC0E6, 16, 0); // reserved bits dropped, leaving 22h
		host.xfer(8'h66, 8, 0);
		host.xfer(8'h00, 8, 0);
		host.xfer(8'h99, 8, 0);
		check(read_parameters, 8'h22);
		host.xfer(8'h06, 8, 0);
		host.xfer(8'h66, 8, 0);
		host.xfer(8'h99, 8, 0);
		check({read_parameters, write_latch_flag}, 9'h000);
	endtask

	// main sequence
	initial
	begin
		reset_n = 1'b0;
		busy_flag = 1'b0;
		host.reset_clocks();
		repeat (2) @(negedge sys_clk);
		reset_n = 1'b1;
		#400;
		t_latch();
		t_dummy();
		t_read();
		t_disc();
		t_modes();
		t_soft_reset();
		give_verdict();
	end

	// watchdog well beyond the few dozen frames above
	initial
	begin
		#300_000;
		num_errors++;
		give_verdict();
	end
endmodule // testbench
